// file: logic/fprsc_params.svh
// offsets, field positions, reset values and fixed patterns of the fp register block
`ifndef FPRSC_PARAMS_SVH
`define FPRSC_PARAMS_SVH
`define FPRSC_ADDR_W 8
`define FPRSC_OFS_CTRL 8'h00
`define FPRSC_OFS_PHYS 8'h80
`define FPRSC_CTRL_RESET 32'h0004_0001
`define FPRSC_CTRL_MASK 32'h003f_ffff
`define FPRSC_BIT_BANK 21
`define FPRSC_BIT_SIZE 20
`define FPRSC_BIT_PREC 19
`define FPRSC_BIT_FLUSH 18
`define FPRSC_CAUSE_HI 17
`define FPRSC_CAUSE_LO 12
`define FPRSC_CAUSE_V 16
`define FPRSC_CAUSE_E 17
`define FPRSC_EN_HI 11
`define FPRSC_EN_LO 7
`define FPRSC_EN_V 11
`define FPRSC_FLAG_HI 6
`define FPRSC_FLAG_LO 2
`define FPRSC_FLAG_V 6
`define FPRSC_RM_HI 1
`define FPRSC_RM_LO 0
`define FPRSC_RM_ZERO 2'h1
`define FPRSC_QNAN_SGL 32'h7fbf_ffff
`define FPRSC_QNAN_DBL 64'h7ff7_ffff_ffff_ffff
`endif

// file: logic/fprsc_pkg.sv
// types shared by the fp register file and status/control block
package fprsc_pkg;
	typedef enum logic [2:0] {
		FPRSC_OP_ARITH,
		FPRSC_OP_COPY,
		FPRSC_OP_ABS,
		FPRSC_OP_NEG,
		FPRSC_OP_MOVE
	} fprsc_op_t;
	typedef struct packed {
		logic valid;
		fprsc_op_t op;
		logic two_src;
		logic dst_ext;
		logic [3:0] dst_idx;
		logic [3:0] srca_idx;
		logic [3:0] srcb_idx;
		logic [4:0] exc_req;
		logic [63:0] result;
	} fprsc_issue_t;
	typedef struct packed {
		logic nan;
		logic snan;
		logic qnan;
		logic denorm;
		logic [63:0] flushed;
	} fprsc_class_t;
	typedef struct packed {
		logic bank;
		logic size;
		logic prec;
		logic flush;
		logic reserved_combo;
		logic round_zero;
		logic [1:0] round;
	} fprsc_mode_t;
	typedef logic [15:0][31:0] fprsc_file_t;
	typedef logic [7:0][63:0] fprsc_dbl_t;
	typedef logic [3:0][127:0] fprsc_vec_t;
	typedef logic [3:0][3:0][31:0] fprsc_mtx_t;
endpackage : fprsc_pkg

// file: logic/fprsc_classify.sv
// nan / denormal classification of a single or double operand
`timescale 1ns/1ps
`default_nettype none
module fprsc_classify (
	input wire logic [63:0] val,
	input wire logic dbl,
	output fprsc_pkg::fprsc_class_t cls
);
	logic exp_ones;
	logic exp_zero;
	logic frac_nz;
	logic frac_msb;
	logic sign;
	always_comb begin
		if (dbl) begin
			exp_ones = &val[62:52];
			exp_zero = ~|val[62:52];
			frac_nz = |val[51:0];
			frac_msb = val[51];
			sign = val[63];
		end else begin
			exp_ones = &val[30:23];
			exp_zero = ~|val[30:23];
			frac_nz = |val[22:0];
			frac_msb = val[22];
			sign = val[31];
		end
		cls.nan = exp_ones & frac_nz;
		cls.snan = exp_ones & frac_nz & frac_msb;
		cls.qnan = exp_ones & frac_nz & ~frac_msb;
		cls.denorm = exp_zero & frac_nz;
		cls.flushed = dbl ? {sign, 63'h0} : {32'h0, sign, 31'h0};
	end
endmodule : fprsc_classify
`default_nettype wire

// file: logic/fprsc_bank.sv
// one bank of sixteen 32-bit fp registers with single or pair write
`timescale 1ns/1ps
`default_nettype none
module fprsc_bank (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic wr_pair,
	input wire logic [3:0] wr_idx,
	input wire logic [63:0] wr_data,
	output fprsc_pkg::fprsc_file_t regs
);
	genvar i;
	generate
		for (i = 0; i < 16; i++) begin : g_ent
			logic [31:0] ent_q;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ent_q <= 32'h0;
				end else if (wr_en && wr_pair && wr_idx[3:1] == 3'(i / 2)) begin
					// even entry holds the upper word of a pair
					ent_q <= (i % 2 == 0) ? wr_data[63:32] : wr_data[31:0];
				end else if (wr_en && !wr_pair && wr_idx == 4'(i)) begin
					ent_q <= wr_data[31:0];
				end
			end
			assign regs[i] = ent_q;
		end
	endgenerate
endmodule : fprsc_bank
`default_nettype wire

// file: logic/fprsc_top.sv
// fp register file, register views and status/control word with apb access
// Notes on behaviour
// - nan is all-ones exponent, nonzero fraction; fraction msb one means signaling.
// - signaling nan into arithmetic with invalid enable clear yields quiet nan.
// - signaling nan with invalid enable set traps and keeps destination.
// - quiet nan without signaling yields quiet nan and no exception.
// - generated quiet nan uses the fixed single and double patterns.
// - zero exponent with nonzero fraction is denormal.
// - flush bit set zeroes denormal sources and results in arithmetic.
// - thirty-two physical 32-bit registers in two banks of sixteen.
// - bank select zero maps single views to bank 0; one swaps.
// - double views pair even single with next odd, extended alike.
// - four vector views of four singles from 0, 4, 8, 12.
// - matrix view column j holds extended registers 4j to 4j+3.
// - status/control word resets to 0x00040001.
// - transfer size bit selects 32-bit or 64-bit pair moves.
// - precision bit selects single or double precision execution.
// - cause at 17..12, enable at 11..7, flag at 6..2.
// - a requested exception sets both cause and flag bits.
// - every arithmetic instruction first clears the whole cause field.
// - flag bits stay set until software writes zero.
// - rounding field 00 nearest, 01 toward zero, others reserved.
// - bits 31..22 read zero; software writes only zero.
// - denormal input with flush clear raises the unmaskable error cause.
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "fprsc_params.svh"
module fprsc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire fprsc_pkg::fprsc_issue_t issue,
	output logic [63:0] opa,
	output logic [63:0] opb,
	output logic exc,
	output fprsc_pkg::fprsc_mode_t mode,
	output fprsc_pkg::fprsc_file_t sview,
	output fprsc_pkg::fprsc_file_t xview,
	output fprsc_pkg::fprsc_dbl_t dview,
	output fprsc_pkg::fprsc_dbl_t xdview,
	output fprsc_pkg::fprsc_vec_t vview,
	output fprsc_pkg::fprsc_mtx_t mview
);
	logic [31:0] ctrl_q;
	logic [31:0] ctrl_d;
	logic [31:0] prdata_q;
	logic exc_q;
	fprsc_pkg::fprsc_file_t bank0;
	fprsc_pkg::fprsc_file_t bank1;
	fprsc_pkg::fprsc_class_t cls [3];
	logic [63:0] cls_in [3];
	logic bank_sel;
	logic dn;
	logic arith;
	logic dbl;
	logic [63:0] src_a;
	logic [63:0] src_b;
	logic in_snan;
	logic in_qnan;
	logic in_den;
	logic [5:0] cause_set;
	logic trap;
	logic wr_en;
	logic [63:0] wr_data;
	logic [63:0] qnan;
	logic tgt_bank;
	logic apb_wr;
	logic apb_setup;
	logic sel_ctrl;
	logic sel_phys;
	logic [31:0] wmask;
	logic [31:0] phys_word;

	assign bank_sel = ctrl_q[`FPRSC_BIT_BANK];
	assign dn = ctrl_q[`FPRSC_BIT_FLUSH];

	// physical storage, two banks of sixteen
	fprsc_bank u_bank0 (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr_en && !tgt_bank),
		.wr_pair(dbl),
		.wr_idx(issue.dst_idx),
		.wr_data(wr_data),
		.regs(bank0)
	);
	fprsc_bank u_bank1 (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr_en && tgt_bank),
		.wr_pair(dbl),
		.wr_idx(issue.dst_idx),
		.wr_data(wr_data),
		.regs(bank1)
	);

	// views follow ctrl_q, so a swap is seen by the very next issue
	assign sview = bank_sel ? bank1 : bank0;
	assign xview = bank_sel ? bank0 : bank1;
	assign tgt_bank = issue.dst_ext ^ bank_sel;

	genvar i;
	genvar r;
	generate
		for (i = 0; i < 8; i++) begin : g_dbl
			assign dview[i] = {sview[2 * i], sview[2 * i + 1]};
			assign xdview[i] = {xview[2 * i], xview[2 * i + 1]};
		end
		for (i = 0; i < 4; i++) begin : g_vec
			assign vview[i] = {sview[4 * i], sview[4 * i + 1], sview[4 * i + 2], sview[4 * i + 3]};
			for (r = 0; r < 4; r++) begin : g_row
				assign mview[i][r] = xview[4 * i + r];
			end
		end
		for (i = 0; i < 3; i++) begin : g_cls
			fprsc_classify u_cls (
				.val(cls_in[i]),
				.dbl(dbl),
				.cls(cls[i])
			);
		end
	endgenerate

	// operating modes seen by the datapath
	always_comb begin
		mode.bank = bank_sel;
		mode.size = ctrl_q[`FPRSC_BIT_SIZE];
		mode.prec = ctrl_q[`FPRSC_BIT_PREC];
		mode.flush = dn;
		// flagged only; the pair is undefined for arithmetic
		mode.reserved_combo = mode.size & mode.prec;
		mode.round = ctrl_q[`FPRSC_RM_HI:`FPRSC_RM_LO];
		mode.round_zero = mode.round == `FPRSC_RM_ZERO;
	end

	// operand width: moves and copies follow transfer size, the rest precision
	always_comb begin
		arith = issue.valid && issue.op == fprsc_pkg::FPRSC_OP_ARITH;
		if (issue.op == fprsc_pkg::FPRSC_OP_MOVE || issue.op == fprsc_pkg::FPRSC_OP_COPY) begin
			dbl = ctrl_q[`FPRSC_BIT_SIZE];
		end else begin
			dbl = ctrl_q[`FPRSC_BIT_PREC];
		end
		if (dbl) begin
			src_a = {sview[{issue.srca_idx[3:1], 1'b0}], sview[{issue.srca_idx[3:1], 1'b1}]};
			src_b = {sview[{issue.srcb_idx[3:1], 1'b0}], sview[{issue.srcb_idx[3:1], 1'b1}]};
			qnan = `FPRSC_QNAN_DBL;
		end else begin
			src_a = {32'h0, sview[issue.srca_idx]};
			src_b = {32'h0, sview[issue.srcb_idx]};
			qnan = {32'h0, `FPRSC_QNAN_SGL};
		end
		cls_in[0] = src_a;
		cls_in[1] = src_b;
		cls_in[2] = issue.result;
	end

	// operands handed to the datapath, flushed when asked
	always_comb begin
		opa = (dn && cls[0].denorm) ? cls[0].flushed : src_a;
		opb = (dn && cls[1].denorm) ? cls[1].flushed : src_b;
	end

	// nan, denormal and exception decisions for arithmetic
	always_comb begin
		in_snan = cls[0].snan | (issue.two_src & cls[1].snan);
		in_qnan = cls[0].qnan | (issue.two_src & cls[1].qnan);
		in_den = cls[0].denorm | (issue.two_src & cls[1].denorm);
		cause_set = {~dn & in_den, in_snan | issue.exc_req[4], issue.exc_req[3:0]};
		// error cause has no enable bit, so it always traps
		trap = arith && (cause_set[5] || |(cause_set[4:0] & ctrl_q[`FPRSC_EN_HI:`FPRSC_EN_LO]));
		wr_en = issue.valid && !trap;
	end

	always_comb begin
		case (issue.op)
			fprsc_pkg::FPRSC_OP_COPY: begin
				wr_data = src_a;
			end
			fprsc_pkg::FPRSC_OP_ABS: begin
				wr_data = src_a;
				if (dbl) begin
					wr_data[63] = 1'b0;
				end else begin
					wr_data[31] = 1'b0;
				end
			end
			fprsc_pkg::FPRSC_OP_NEG: begin
				wr_data = src_a;
				if (dbl) begin
					wr_data[63] = ~src_a[63];
				end else begin
					wr_data[31] = ~src_a[31];
				end
			end
			fprsc_pkg::FPRSC_OP_MOVE: begin
				wr_data = issue.result;
			end
			fprsc_pkg::FPRSC_OP_ARITH: begin
				if (in_snan || in_qnan) begin
					wr_data = qnan;
				end else if (dn && cls[2].denorm) begin
					wr_data = cls[2].flushed;
				end else begin
					wr_data = issue.result;
				end
			end
			default: begin
				wr_data = issue.result;
			end
		endcase
	end

	// apb decode; zero wait states
	assign apb_setup = psel && !penable;
	assign apb_wr = psel && penable && pwrite && sel_ctrl;
	assign sel_ctrl = paddr == `FPRSC_OFS_CTRL;
	assign sel_phys = paddr[7] && paddr[1:0] == 2'h0;
	assign pready = 1'b1;
	// physical registers are a read-only window
	assign pslverr = psel && penable && (pwrite ? !sel_ctrl : !(sel_ctrl || sel_phys));
	assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	assign phys_word = paddr[6] ? bank1[paddr[5:2]] : bank0[paddr[5:2]];

	// status/control next value: apb write, then hardware sets on top
	always_comb begin
		ctrl_d = ctrl_q;
		if (apb_wr) begin
			ctrl_d = ((ctrl_q & ~wmask) | (pwdata & wmask)) & `FPRSC_CTRL_MASK;
		end
		if (arith) begin
			ctrl_d[`FPRSC_CAUSE_HI:`FPRSC_CAUSE_LO] = cause_set;
			// set beats a same-cycle software clear
			ctrl_d[`FPRSC_FLAG_HI:`FPRSC_FLAG_LO] = ctrl_d[`FPRSC_FLAG_HI:`FPRSC_FLAG_LO] | cause_set[4:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `FPRSC_CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exc_q <= 1'b0;
		end else begin
			exc_q <= trap;
		end
	end
	assign exc = exc_q;

	// read data captured in the setup cycle so it comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0;
		end else if (apb_setup) begin
			if (paddr == `FPRSC_OFS_CTRL) begin
				prdata_q <= ctrl_q & `FPRSC_CTRL_MASK;
			end else if (paddr[7] && paddr[1:0] == 2'h0) begin
				prdata_q <= phys_word;
			end else begin
				prdata_q <= 32'h0;
			end
		end
	end
	assign prdata = prdata_q;

	AST_RESERVED_ZERO: assert property (
		@(posedge pclk) disable iff (!presetn)
		ctrl_q[31:22] == 10'h0)
		else $error("reserved control bits not zero");

	AST_SNAN_TRAP: assert property (
		@(posedge pclk) disable iff (!presetn)
		arith && in_snan && ctrl_q[`FPRSC_EN_V]
		|-> !wr_en ##1 (exc && ctrl_q[`FPRSC_CAUSE_V]))
		else $error("enabled signaling nan did not trap");

	AST_SNAN_QUIET: assert property (
		@(posedge pclk) disable iff (!presetn)
		arith && in_snan && !trap |-> wr_en && wr_data == qnan)
		else $error("signaling nan did not give quiet nan");

	AST_QNAN_SILENT: assert property (
		@(posedge pclk) disable iff (!presetn)
		arith && in_qnan && !in_snan && !in_den && issue.exc_req == 5'h0
		|-> ##1 !exc && ctrl_q[`FPRSC_CAUSE_HI:`FPRSC_CAUSE_LO] == 6'h0)
		else $error("quiet nan raised an exception");

	AST_QNAN_PATTERN: assert property (
		@(posedge pclk) disable iff (!presetn)
		arith && !dbl && in_qnan && wr_en |-> wr_data == 64'h0000_0000_7fbf_ffff)
		else $error("wrong single quiet nan pattern");

	AST_FLUSH_RESULT: assert property (
		@(posedge pclk) disable iff (!presetn)
		arith && dn && !in_snan && !in_qnan && cls[2].denorm
		|-> wr_data == cls[2].flushed)
		else $error("denormal result not flushed");

	AST_DENORM_ERROR: assert property (
		@(posedge pclk) disable iff (!presetn)
		arith && !dn && cls[0].denorm
		|-> ##1 exc && ctrl_q[`FPRSC_CAUSE_E])
		else $error("denormal input did not raise error");

	AST_FLAG_STICKY: assert property (
		@(posedge pclk) disable iff (!presetn)
		$fell(ctrl_q[`FPRSC_FLAG_V]) |-> $past(apb_wr) && !($past(arith) && $past(cause_set[4])))
		else $error("flag cleared without software write");

	AST_CAUSE_CLEAR: assert property (
		@(posedge pclk) disable iff (!presetn)
		arith && cause_set == 6'h0 |=> ctrl_q[`FPRSC_CAUSE_HI:`FPRSC_CAUSE_LO] == 6'h0)
		else $error("cause field not cleared");

	AST_BANK_MAP: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(bank_sel) |-> sview[0] == bank1[0] && xview[15] == bank0[15])
		else $error("bank swap not applied");

	AST_FLAG_SET: assert property (
		@(posedge pclk) disable iff (!presetn)
		arith && cause_set[4] |=> ctrl_q[`FPRSC_CAUSE_V] && ctrl_q[`FPRSC_FLAG_V])
		else $error("invalid request did not set cause and flag");

	AST_QNAN_DOUBLE: assert property (
		@(posedge pclk) disable iff (!presetn)
		arith && dbl && (in_snan || in_qnan) && wr_en |-> wr_data == 64'h7ff7_ffff_ffff_ffff)
		else $error("wrong double quiet nan pattern");

	AST_COPY_RAW: assert property (
		@(posedge pclk) disable iff (!presetn)
		issue.valid && issue.op == fprsc_pkg::FPRSC_OP_COPY |-> wr_en && wr_data == src_a)
		else $error("copy altered its operand");
endmodule : fprsc_top
`default_nettype wire

// file: testbench/fprsc_cpu_model.sv
// cpu issue-side model: one-cycle instruction pulses, operand and trap capture
`timescale 1ns/1ps
`default_nettype none
module fprsc_cpu_model (
	input wire logic pclk,
	input wire logic [63:0] opa,
	input wire logic [63:0] opb,
	input wire logic exc,
	output fprsc_pkg::fprsc_issue_t issue
);
	logic [63:0] opa_seen;
	logic [63:0] opb_seen;
	logic exc_seen;
	initial issue = '0;
	task automatic exec(input fprsc_pkg::fprsc_issue_t r);
		@(posedge pclk) issue <= r;
		#1 opa_seen = opa;
		opb_seen = opb;
		// idle fields flip so a stale instruction never looks live
		@(posedge pclk) issue <= {1'b0, ~r[$bits(r)-2:0]};
		#1 exc_seen = exc;
	endtask : exec
endmodule : fprsc_cpu_model
`default_nettype wire

// file: testbench/fprsc_top_tb.sv
// self-checking bench of the fp register file and status/control block
`timescale 1ns/1ps
`default_nettype none
module fprsc_top_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, exc, rerr, bsel;
	logic [7:0] paddr;
	logic [3:0] pstrb;
	logic [31:0] pwdata, prdata, rdv, x;
	logic [31:0] seed = 32'hfd308a43;
	logic [63:0] opa, opb, w;
	logic [31:0] bk [2][16];
	int num_errors, checks_done, cyc;
	fprsc_pkg::fprsc_issue_t issue;
	fprsc_pkg::fprsc_mode_t mode;
	fprsc_pkg::fprsc_file_t sview, xview;
	fprsc_pkg::fprsc_dbl_t dview, xdview;
	fprsc_pkg::fprsc_vec_t vview;
	fprsc_pkg::fprsc_mtx_t mview;
	fprsc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.issue(issue), .opa(opa), .opb(opb), .exc(exc), .mode(mode), .sview(sview), .xview(xview),
		.dview(dview), .xdview(xdview), .vview(vview), .mview(mview));
	fprsc_cpu_model u_cpu (.pclk(pclk), .opa(opa), .opb(opb), .exc(exc), .issue(issue));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			num_errors = num_errors + 1;
			conclude();
		end
	end
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	// exponent pinned so random data never lands on nan or denormal
	function automatic logic [31:0] nrm(input logic [31:0] v);
		return {v[31], 8'h40, v[22:0]};
	endfunction : nrm
	function automatic logic [31:0] snan(input logic [31:0] v);
		return {v[31], 9'h1ff, v[21:0]};
	endfunction : snan
	function automatic logic [31:0] qnan(input logic [31:0] v);
		return {v[31], 9'h1fe, v[21:1], 1'b1};
	endfunction : qnan
	function automatic logic [31:0] den(input logic [31:0] v);
		return {v[31], 8'h00, v[22:1], 1'b1};
	endfunction : den
	task automatic chk(input logic [127:0] s, input logic [127:0] e);
		checks_done = checks_done + 1;
		if (s !== e) begin
			num_errors = num_errors + 1;
			$display("mismatch at %0t: saw %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic apb(input logic wrt, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk) begin
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= wrt;
			paddr <= a;
			pwdata <= d;
		end
		@(posedge pclk) penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdv = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wc(input logic [31:0] d);
		apb(1'b1, 8'h00, d);
		bsel = d[21];
	endtask : wc
	task automatic run(input fprsc_pkg::fprsc_op_t o, input logic [3:0] d, input logic [3:0] a,
		input logic [4:0] xr, input logic [63:0] res);
		fprsc_pkg::fprsc_issue_t r;
		r = '0;
		r.valid = 1'b1;
		r.op = o;
		r.dst_idx = d;
		r.srca_idx = a;
		r.srcb_idx = a;
		r.exc_req = xr;
		r.result = res;
		u_cpu.exec(r);
	endtask : run
	task automatic mv(input logic e, input logic [3:0] d, input logic [31:0] v);
		fprsc_pkg::fprsc_issue_t r;
		r = '0;
		r.valid = 1'b1;
		r.op = fprsc_pkg::FPRSC_OP_MOVE;
		r.dst_ext = e;
		r.dst_idx = d;
		r.result = {32'h0, v};
		u_cpu.exec(r);
		bk[bsel ^ e][d] = v;
	endtask : mv
	task automatic views(input logic s);
		for (int i = 0; i < 16; i++) begin
			chk(sview[i], bk[s][i]);
			chk(xview[i], bk[!s][i]);
			chk(mview[i / 4][i % 4], bk[!s][i]);
		end
		for (int i = 0; i < 8; i++) begin
			chk(dview[i], {bk[s][2 * i], bk[s][2 * i + 1]});
			chk(xdview[i], {bk[!s][2 * i], bk[!s][2 * i + 1]});
		end
		for (int i = 0; i < 4; i++) chk(vview[i], {bk[s][4 * i], bk[s][4 * i + 1], bk[s][4 * i + 2], bk[s][4 * i + 3]});
		for (int i = 0; i < 32; i++) begin
			apb(1'b0, 8'h80 + 8'(4 * i), 32'h0);
			chk(rdv, bk[i / 16][i % 16]);
		end
	endtask : views
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, bsel} = '0;
		pstrb = 4'hf;
		bk = '{default: '0};
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h00, 32'h0);
		chk(rdv, 32'h0004_0001);
		chk(mode.round_zero, 1'b1);
		apb(1'b0, 8'h04, 32'h0);
		chk({rdv, rerr}, 33'h1);
		apb(1'b1, 8'h80, 32'h1);
		chk(rerr, 1'b1);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			x = xs();
			x[1:0] = i[1:0];
			x[31:22] = 10'h0;
			if (x[20]) x[19] = 1'b0;
			wc(x);
			apb(1'b0, 8'h00, 32'h0);
			chk(rdv, x & 32'h003f_ffff);
			chk(mode.round_zero, x[1:0] == 2'b01);
			chk({mode.size, mode.prec, mode.bank}, {x[20], x[19], x[21]});
			chk({mode.flush, mode.round, mode.reserved_combo}, {x[18], x[1:0], 1'b0});
		end
		$display("test control word done");
		wc(32'h0);
		for (int i = 0; i < 32; i++) mv(i[4], i[3:0], nrm(xs()));
		views(1'b0);
		wc(32'h0020_0000);
		mv(1'b0, 4'h0, nrm(xs()));
		chk(sview[0], bk[1][0]);
		views(1'b1);
		wc(32'h0010_0000);
		w = {nrm(xs()), nrm(xs())};
		run(fprsc_pkg::FPRSC_OP_MOVE, 4'h4, 4'h0, 5'h0, w);
		{bk[0][4], bk[0][5]} = w;
		chk(dview[2], w);
		views(1'b0);
		$display("test views done");
		wc(32'h0);
		mv(1'b0, 4'h1, snan(xs()));
		run(fprsc_pkg::FPRSC_OP_ARITH, 4'h3, 4'h1, 5'h0, 64'h0);
		chk(sview[3], 32'h7fbf_ffff);
		chk(u_cpu.exc_seen, 1'b0);
		apb(1'b0, 8'h00, 32'h0);
		chk({rdv[17:12], rdv[6:2]}, {6'h10, 5'h10});
		run(fprsc_pkg::FPRSC_OP_ARITH, 4'h5, 4'h0, 5'h0, {32'h0, w[31:0]});
		chk(sview[5], w[31:0]);
		apb(1'b0, 8'h00, 32'h0);
		chk({rdv[17:12], rdv[6:2]}, {6'h00, 5'h10});
		wc(32'h0000_0800);
		run(fprsc_pkg::FPRSC_OP_ARITH, 4'h2, 4'h1, 5'h0, 64'h0);
		chk(u_cpu.exc_seen, 1'b1);
		chk(sview[2], bk[0][2]);
		mv(1'b0, 4'h1, qnan(xs()));
		run(fprsc_pkg::FPRSC_OP_ARITH, 4'h2, 4'h1, 5'h0, 64'h0);
		chk(sview[2][30:22], 9'h1fe);
		chk(u_cpu.exc_seen, 1'b0);
		apb(1'b0, 8'h00, 32'h0);
		chk(rdv[17:12], 6'h0);
		x = xs();
		mv(1'b0, 4'h8, {x[31], 12'hfff, x[18:0]});
		mv(1'b0, 4'h9, xs());
		wc(32'h0008_0000);
		run(fprsc_pkg::FPRSC_OP_ARITH, 4'ha, 4'h8, 5'h0, 64'h0);
		chk(dview[5], 64'h7ff7_ffff_ffff_ffff);
		$display("test nan done");
		wc(32'h0004_0000);
		x = den(xs());
		mv(1'b0, 4'h6, x);
		chk(sview[6], x);
		run(fprsc_pkg::FPRSC_OP_ARITH, 4'h7, 4'h6, 5'h0, 64'h0);
		chk(u_cpu.opa_seen[30:0], 31'h0);
		chk(u_cpu.opb_seen[30:0], 31'h0);
		run(fprsc_pkg::FPRSC_OP_COPY, 4'hd, 4'h6, 5'h0, 64'h0);
		chk(sview[13], x);
		run(fprsc_pkg::FPRSC_OP_ABS, 4'he, 4'h6, 5'h0, 64'h0);
		chk(sview[14], {1'b0, x[30:0]});
		run(fprsc_pkg::FPRSC_OP_NEG, 4'hf, 4'h6, 5'h0, 64'h0);
		chk(sview[15], {~x[31], x[30:0]});
		wc(32'h0);
		run(fprsc_pkg::FPRSC_OP_ARITH, 4'h7, 4'h6, 5'h0, 64'h0);
		chk(u_cpu.opa_seen[31:0], x);
		chk(u_cpu.opb_seen[31:0], x);
		chk(u_cpu.exc_seen, 1'b1);
		apb(1'b0, 8'h00, 32'h0);
		chk(rdv[17], 1'b1);
		$display("test denormal done");
		for (int i = 0; i < 4; i++) begin
			wc(32'h0);
			x = xs();
			w = {32'h0, nrm(xs())};
			run(fprsc_pkg::FPRSC_OP_ARITH, 4'hc, 4'h0, x[4:0], w);
			chk(sview[12], w[31:0]);
			apb(1'b0, 8'h00, 32'h0);
			chk({rdv[16:12], rdv[6:2]}, {x[4:0], x[4:0]});
		end
		wc(32'h0000_0400);
		run(fprsc_pkg::FPRSC_OP_ARITH, 4'hc, 4'h0, 5'h08, 64'h0);
		chk(u_cpu.exc_seen, 1'b1);
		chk(sview[12], w[31:0]);
		$display("test exceptions done");
		// second reset in mid-run: every register and the control word return to power-on values
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		bk = '{default: '0};
		bsel = 1'b0;
		views(1'b0);
		apb(1'b0, 8'h00, 32'h0);
		chk(rdv, 32'h0004_0001);
		$display("test reset again done");
		conclude();
	end
endmodule : fprsc_top_tb
`default_nettype wire
